/* File: hw/epwm_defs.vh */
`ifndef EPWM_DEFS_VH
`define EPWM_DEFS_VH
// Register byte addresses
`define EPWM_A_PERIOD 12'h000
`define EPWM_A_TIMER 12'h004
`define EPWM_A_DUTYBUF 12'h008
`define EPWM_A_DUTYACT 12'h00C
`define EPWM_A_MODE 12'h010
`define EPWM_A_TCTRL 12'h014
`define EPWM_A_SHDN 12'h018
`define EPWM_A_EPCTL 12'h01C
`define EPWM_A_STAT 12'h020
`define EPWM_A_PINDIR 12'h024
// Reset values
`define EPWM_RST_PERIOD 8'hFF
`define EPWM_RST_ZERO8 8'h00
`define EPWM_RST_PINDIR 4'hF
// Field positions
`define EPWM_MODE_DLO_HI 5
`define EPWM_MODE_DLO_LO 4
`define EPWM_MODE_SEL_HI 3
`define EPWM_MODE_SEL_LO 2
`define EPWM_MODE_PWM 2'h3
`define EPWM_SH_STATUS 7
`define EPWM_SH_INTSEL 6
`define EPWM_SH_UNUSED 5
`define EPWM_SH_P4SEL 4
`define EPWM_SH_AC_HI 3
`define EPWM_SH_AC_LO 2
`define EPWM_SH_BD_HI 1
`define EPWM_SH_BD_LO 0
`define EPWM_EP_RESTART 7
`define EPWM_TC_RUN 2
`define EPWM_TC_PS_HI 1
`define EPWM_TC_PS_LO 0
`define EPWM_ST_FLAG 0
// Prescale codes and counts
`define EPWM_PS_1 2'h0
`define EPWM_PS_4 2'h1
`define EPWM_PRE4_LAST 2'h3
`define EPWM_PRE16_LAST 4'hF
`define EPWM_PHASE_LAST 2'h3
`endif

/* File: hw/epwm_core.v */
// How it works
// - Period match clears timer, sets pin, latches duty
// - Duty is buffer byte plus mode bits 5:4
// - Duty writes double-buffered until period end
// - Active duty latch read-only in PWM mode
// - Time base: timer plus phase or prescale bits
// - Time base equals duty: pin goes low
// - Period is (period+1) times 4 times prescale
// - Width beyond period leaves pins unchanged
// - Prescale ratios 1, 4 and 16
// - Ten bits resolution at period 255
// - Sleep freezes timer and state, holds outputs
// - Reset makes pins inputs, registers reset
// - Shutdown by software, int pin or pin four
// - Shutdown status sticky until cleared or restart
// - Shutdown drives pairs low, high or tri-state
// - Pair states from bits 3-2 and 1-0
// - Shutdown level-sensitive, held while level present
// - Status writes ignored while condition present
// - Output resumes at start of next period
// - Auto-restart clears status once condition gone
// - Shutdown bit 5 reads zero
// - Enhanced control bit 7 enables auto-restart
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "epwm_defs.vh"
module epwm_core (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Device control and pins
    input wire sleep,
    input wire int_pin,
    input wire port_pin_four,
    output reg timer_match_flag,
    output reg [3:0] pwm_out,
    output reg [3:0] pwm_oen
);
    ////////////////////////////////////////////////////////////////////////
    reg [7:0] period_register;
    reg [7:0] period_timer;
    reg [7:0] duty_buffer_register;
    reg [7:0] active_duty_latch;
    reg [7:0] mode_control_register;
    reg [2:0] timer_ctrl;
    reg [7:0] auto_shutdown_control;
    reg [7:0] enhanced_pwm_control;
    reg [3:0] pin_direction_bit;
    reg [1:0] duty_low_latch;
    reg [3:0] prescale_cnt;
    reg [1:0] phase_cnt;
    reg pwm_level;
    reg width_over;
    reg [1:0] int_sync;
    reg [1:0] p4_sync;
    reg wr_pend;
    reg [11:0] wr_addr;
    ////////////////////////////////////////////////////////////////////////
    reg [31:0] next_hrdata;
    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire bus_go = hsel & hready & htrans[1];
    wire rd_go = bus_go & ~hwrite;
    wire [7:0] wd = hwdata[7:0];
    wire wr_sh = wr_pend & (wr_addr == `EPWM_A_SHDN);
    wire wr_stat = wr_pend & (wr_addr == `EPWM_A_STAT);
    wire wr_timer = wr_pend & (wr_addr == `EPWM_A_TIMER);
    wire wr_dutyact = wr_pend & (wr_addr == `EPWM_A_DUTYACT);
    ////////////////////////////////////////////////////////////////////////
    // Mode and time base
    wire pwm_mode = mode_control_register[`EPWM_MODE_SEL_HI:`EPWM_MODE_SEL_LO]
        == `EPWM_MODE_PWM;
    wire run = timer_ctrl[`EPWM_TC_RUN] & ~sleep;
    wire [1:0] ps_sel = timer_ctrl[`EPWM_TC_PS_HI:`EPWM_TC_PS_LO];
    // Instruction cycle every four clocks
    wire instr = run & (phase_cnt == `EPWM_PHASE_LAST);
    wire pre_last = (ps_sel == `EPWM_PS_1) ? 1'b1 :
        (ps_sel == `EPWM_PS_4) ? (prescale_cnt[1:0] == `EPWM_PRE4_LAST) :
        (prescale_cnt == `EPWM_PRE16_LAST);
    wire step = instr & pre_last;
    wire [1:0] low_bits = (ps_sel == `EPWM_PS_1) ? phase_cnt :
        (ps_sel == `EPWM_PS_4) ? prescale_cnt[1:0] : prescale_cnt[3:2];
    // Full ten bits at period 255
    wire [9:0] time_base = {period_timer, low_bits};
    wire [9:0] duty_act = {active_duty_latch, duty_low_latch};
    wire [9:0] duty_new = {duty_buffer_register,
        mode_control_register[`EPWM_MODE_DLO_HI:`EPWM_MODE_DLO_LO]};
    wire [9:0] period_top = {period_register, `EPWM_PHASE_LAST};
    // Period ends after timer equals period register
    wire period_end = step & (period_timer == period_register);
    // Match clears level in its first cycle
    wire clear_hit = run & ~width_over & (time_base == duty_act);
    wire pwm_now = pwm_level & ~clear_hit;
    ////////////////////////////////////////////////////////////////////////
    // Shutdown sources, synchronised pins
    wire cond = (auto_shutdown_control[`EPWM_SH_INTSEL] & ~int_sync[1]) |
        (auto_shutdown_control[`EPWM_SH_P4SEL] & ~p4_sync[1]);
    wire sh_status = auto_shutdown_control[`EPWM_SH_STATUS];
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_sync <= 2'h3;
            p4_sync <= 2'h3;
        end else begin
            int_sync <= {int_sync[0], int_pin};
            p4_sync <= {p4_sync[0], port_pin_four};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data select
    always @* begin
        next_hrdata = 32'h0000_0000;
        case (haddr)
            `EPWM_A_PERIOD: next_hrdata = {24'h00_0000, period_register};
            `EPWM_A_TIMER: next_hrdata = {24'h00_0000, period_timer};
            `EPWM_A_DUTYBUF: next_hrdata = {24'h00_0000, duty_buffer_register};
            `EPWM_A_DUTYACT: next_hrdata = {24'h00_0000, active_duty_latch};
            `EPWM_A_MODE: next_hrdata = {24'h00_0000, mode_control_register};
            `EPWM_A_TCTRL: next_hrdata = {29'h0000_0000, timer_ctrl};
            `EPWM_A_SHDN: next_hrdata = {24'h00_0000, auto_shutdown_control};
            `EPWM_A_EPCTL: next_hrdata = {24'h00_0000, enhanced_pwm_control};
            `EPWM_A_STAT: next_hrdata = {30'h0000_0000, cond, timer_match_flag};
            `EPWM_A_PINDIR: next_hrdata = {28'h000_0000, pin_direction_bit};
            default: next_hrdata = 32'h0000_0000;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // Bus data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            // Zero wait states, always okay
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= bus_go & hwrite;
            wr_addr <= haddr;
            if (rd_go) begin
                hrdata <= next_hrdata;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_register <= `EPWM_RST_PERIOD;
            duty_buffer_register <= `EPWM_RST_ZERO8;
            mode_control_register <= `EPWM_RST_ZERO8;
            timer_ctrl <= 3'h0;
            enhanced_pwm_control <= `EPWM_RST_ZERO8;
            pin_direction_bit <= `EPWM_RST_PINDIR;
        end else if (wr_pend) begin
            case (wr_addr)
                `EPWM_A_PERIOD: period_register <= wd;
                // Writes go to buffer at any time
                `EPWM_A_DUTYBUF: duty_buffer_register <= wd;
                `EPWM_A_MODE: mode_control_register <= wd;
                `EPWM_A_TCTRL: timer_ctrl <= wd[2:0];
                `EPWM_A_EPCTL: enhanced_pwm_control <= wd;
                `EPWM_A_PINDIR: pin_direction_bit <= wd[3:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Shutdown control and status
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_shutdown_control <= `EPWM_RST_ZERO8;
        end else begin
            // Shutdown control, bit 5 kept zero
            if (wr_sh) begin
                auto_shutdown_control[6:0] <=
                    {wd[`EPWM_SH_INTSEL], 1'b0, wd[`EPWM_SH_P4SEL:`EPWM_SH_BD_LO]};
            end
            if (wr_sh & ~cond) begin
                auto_shutdown_control[`EPWM_SH_STATUS] <= wd[`EPWM_SH_STATUS];
            end
            if (enhanced_pwm_control[`EPWM_EP_RESTART] & ~cond & sh_status & ~wr_sh) begin
                auto_shutdown_control[`EPWM_SH_STATUS] <= 1'b0;
            end
            // Event sets sticky status, set wins
            if (cond) begin
                auto_shutdown_control[`EPWM_SH_STATUS] <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Sleep freezes counters and state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_cnt <= 2'h0;
            prescale_cnt <= 4'h0;
        end else if (run) begin
            phase_cnt <= phase_cnt + 2'h1;
            if (instr) begin
                prescale_cnt <= step ? 4'h0 : prescale_cnt + 4'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Period timer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_timer <= `EPWM_RST_ZERO8;
        end else if (period_end) begin
            period_timer <= `EPWM_RST_ZERO8;
        end else if (step) begin
            period_timer <= period_timer + 8'h01;
        end else if (wr_timer) begin
            period_timer <= wd;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Duty double buffer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_duty_latch <= `EPWM_RST_ZERO8;
            duty_low_latch <= 2'h0;
            width_over <= 1'b0;
        end else if (period_end) begin
            active_duty_latch <= duty_buffer_register;
            duty_low_latch <= mode_control_register[`EPWM_MODE_DLO_HI:`EPWM_MODE_DLO_LO];
            // Width over period: no clearing edge
            width_over <= duty_new > period_top;
        end else if (wr_dutyact & ~pwm_mode) begin
            active_duty_latch <= wd;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Timer match flag, set wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_match_flag <= 1'b0;
        end else if (period_end) begin
            timer_match_flag <= 1'b1;
        end else if (wr_stat & wd[`EPWM_ST_FLAG]) begin
            timer_match_flag <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // PWM level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_level <= 1'b0;
        end else if (!pwm_mode | sh_status) begin
            pwm_level <= 1'b0;
        end else if (period_end) begin
            pwm_level <= (duty_new != 10'h000) & ~cond;
        end else if (clear_hit) begin
            pwm_level <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Output pins, pair A/C bits 0 and 2, B/D bits 1 and 3
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_pin
            wire [1:0] st = (i == 0 || i == 2) ?
                auto_shutdown_control[`EPWM_SH_AC_HI:`EPWM_SH_AC_LO] :
                auto_shutdown_control[`EPWM_SH_BD_HI:`EPWM_SH_BD_LO];
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pwm_out[i] <= 1'b0;
                    pwm_oen[i] <= 1'b1;
                end else if (!sleep) begin
                    if (sh_status | cond) begin
                        pwm_out[i] <= st[0];
                        pwm_oen[i] <= pin_direction_bit[i] | st[1];
                    end else begin
                        pwm_out[i] <= (i == 0 || i == 2) ? pwm_now : ~pwm_now;
                        pwm_oen[i] <= pin_direction_bit[i];
                    end
                end
            end
        end
    endgenerate
endmodule // epwm_core
`default_nettype wire

/* File: tb/epwm_load.sv */
`timescale 1ns/100ps
`default_nettype none
module epwm_load (
    // Bridge drive
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_oen,
    // Fault requests
    input wire logic fault_int,
    input wire logic fault_p4,
    // Levels seen
    output logic [3:0] pin,
    output logic int_pin,
    output logic port_pin_four
);
    assign pin = pwm_out & ~pwm_oen;
    assign int_pin = ~fault_int;
    assign port_pin_four = ~fault_p4;
endmodule // epwm_load
`default_nettype wire

/* File: tb/epwm_core_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "epwm_defs.vh"
module epwm_core_checker (
    // Clock, reset and bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Pins
    input wire sleep,
    input wire int_pin,
    input wire port_pin_four,
    input wire timer_match_flag,
    input wire [3:0] pwm_out,
    input wire [3:0] pwm_oen
);
    reg rd_ph;
    reg wr_ph;
    reg [11:0] ph_addr;
    reg [7:0] shdn;
    reg [3:0] pdir;
    wire fault = (shdn[6] & ~int_pin) | (shdn[4] & ~port_pin_four);
    wire ac_ok = shdn[3] ? (pwm_oen[0] & pwm_oen[2]) :
        &(pwm_oen[2:0] | ~(pwm_out[2:0] ^ {3{shdn[2]}}) | 3'h2);
    wire bd_ok = shdn[1] ? (pwm_oen[1] & pwm_oen[3]) :
        &(pwm_oen[3:1] | ~(pwm_out[3:1] ^ {3{shdn[0]}}) | 3'h2);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Shadow of register writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
            ph_addr <= 12'h000;
            shdn <= 8'h00;
            pdir <= 4'hF;
        end else if (hready) begin
            rd_ph <= hsel & htrans[1] & ~hwrite;
            wr_ph <= hsel & htrans[1] & hwrite;
            ph_addr <= haddr;
            if (wr_ph && ph_addr == `EPWM_A_SHDN) begin
                shdn <= hwdata[7:0];
            end
            if (wr_ph && ph_addr == `EPWM_A_PINDIR) begin
                pdir <= hwdata[3:0];
            end
        end
    end
    sequence s_fault_held;
        fault [*6];
    endsequence
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reset_pins: assert property ($rose(hresetn) |-> pwm_oen == 4'hF && !timer_match_flag)
        else $error("pins or flag wrong after reset");
    a_dir_input: assert property (($past(pdir, 2) & $past(pdir) & ~pwm_oen) == 4'h0)
        else $error("input pin is driven");
    a_sleep_hold: assert property (sleep [*2] |=> $stable(pwm_out) && $stable(pwm_oen))
        else $error("outputs moved in sleep");
    a_pair_ac: assert property (s_fault_held |-> ac_ok)
        else $error("pair A C not in shutdown state");
    a_pair_bd: assert property (s_fault_held |-> bd_ok)
        else $error("pair B D not in shutdown state");
    a_bit5_zero: assert property (rd_ph && ph_addr == `EPWM_A_SHDN |-> !hrdata[5])
        else $error("shutdown bit 5 reads one");
    a_upper_zero: assert property (rd_ph |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
endmodule // epwm_core_checker
bind epwm_core epwm_core_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sleep, .int_pin, .port_pin_four,
    .timer_match_flag, .pwm_out, .pwm_oen);
`default_nettype wire

/* File: tb/enhanced_pwm_auto_shutdown_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "epwm_defs.vh"
module enhanced_pwm_auto_shutdown_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic sleep = 1'b0;
    logic fault_int = 1'b0;
    logic fault_p4 = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] q;
    wire [31:0] hrdata;
    wire hreadyout, hresp, timer_match_flag, int_pin, port_pin_four;
    wire [3:0] pwm_out, pwm_oen, pin;
    integer fail_count = 0, total_checks = 0, cycles = 0, seed = 32'hC880;
    integer d, ps, psv, ones, i;
    epwm_core DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sleep, .int_pin, .port_pin_four,
        .timer_match_flag, .pwm_out, .pwm_oen);
    epwm_load load (.pwm_out, .pwm_oen, .fault_int, .fault_p4, .pin, .int_pin, .port_pin_four);
    initial forever #50 hclk = ~hclk;
    task print_verdict;
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            $display("Error at %0t: seen %h expected %h", $time, s, e);
            fail_count++;
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Model: high cycles in one period at period register 3
    task measure;
        ones = 0;
        repeat (16 * psv) begin
            @(negedge hclk);
            ones += (pin[0] === 1'b1);
        end
        chk(ones, d == 0 ? 0 : d > 15 ? 16 * psv : d * psv);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`EPWM_A_PERIOD, 32'hFF);
        rdc(`EPWM_A_PINDIR, 32'hF);
        rdc(`EPWM_A_STAT, 32'h0);
        bus(1'b1, 12'h030, 32'hFF);
        rdc(12'h030, 32'h0);
        bus(1'b1, `EPWM_A_SHDN, 32'h20);
        rdc(`EPWM_A_SHDN, 32'h0);
        bus(1'b1, `EPWM_A_PERIOD, 32'h3);
        bus(1'b1, `EPWM_A_MODE, 32'h0C);
        bus(1'b1, `EPWM_A_TCTRL, 32'h4);
        while (timer_match_flag !== 1'b1) @(posedge hclk);
        rdc(`EPWM_A_STAT, 32'h1);
        bus(1'b1, `EPWM_A_PINDIR, 32'h0);
        for (ps = 0; ps < 4; ps++) begin
            psv = ps == 3 ? 16 : 1 << (2 * ps);
            for (i = 0; i < 3; i++) begin
                d = {$random(seed)} % 20;
                bus(1'b1, `EPWM_A_DUTYBUF, d >> 2);
                bus(1'b1, `EPWM_A_MODE, 32'h0C | ((d % 4) << 4));
                bus(1'b1, `EPWM_A_TCTRL, 32'h4 | ps);
                repeat (32 * psv) @(posedge hclk);
                measure;
                rdc(`EPWM_A_DUTYACT, d >> 2);
            end
        end
        bus(1'b1, `EPWM_A_DUTYACT, 32'hAA);
        rdc(`EPWM_A_DUTYACT, d >> 2);
        bus(1'b1, `EPWM_A_SHDN, 32'h44);
        fault_int <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(pin, 32'h5);
        bus(1'b1, `EPWM_A_SHDN, 32'h44);
        rdc(`EPWM_A_SHDN, 32'hC4);
        fault_int <= 1'b0;
        repeat (64) @(posedge hclk);
        rdc(`EPWM_A_SHDN, 32'hC4);
        bus(1'b1, `EPWM_A_SHDN, 32'h44);
        rdc(`EPWM_A_SHDN, 32'h44);
        bus(1'b1, `EPWM_A_EPCTL, 32'h80);
        bus(1'b1, `EPWM_A_SHDN, 32'h1B);
        fault_p4 <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(pwm_oen, 32'hF);
        rdc(`EPWM_A_SHDN, 32'h9B);
        fault_p4 <= 1'b0;
        repeat (32 * psv) @(posedge hclk);
        rdc(`EPWM_A_SHDN, 32'h1B);
        measure;
        bus(1'b1, `EPWM_A_EPCTL, 32'h0);
        bus(1'b1, `EPWM_A_SHDN, 32'h81);
        repeat (4) @(posedge hclk);
        chk(pin, 32'hA);
        bus(1'b1, `EPWM_A_SHDN, 32'h01);
        sleep <= 1'b1;
        repeat (100) @(posedge hclk);
        sleep <= 1'b0;
        repeat (32 * psv) @(posedge hclk);
        measure;
        print_verdict;
    end
endmodule // enhanced_pwm_auto_shutdown_test
`default_nettype wire
